//--- src/qbsid_top.sv
/*
 QBus slave image decoder: register file, image choice, translation
 and response decode, plus the posted-write error log.
 Assumes a synchronous QBus request strobe, a separate PCI reset for
 image 0 translation, and an Avalon-MM master that holds requests.
*/
`timescale 1ns/1ps
module qbsid_top (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     pci_rst_n,
  input  wire logic [qbsid_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     rom_load,
  input  wire logic [31:0]              rom_img0_ctl,
  input  wire logic [31:0]              rom_img0_at,
  input  wire logic                     qb_req,
  input  wire logic                     bridge_chip_select_n,
  input  wire qbsid_pkg::qbsid_req_s    qb_req_info,
  output logic                          pci_valid,
  output qbsid_pkg::qbsid_res_s         pci_res,
  input  wire logic                     pw_err,
  input  wire qbsid_pkg::qbsid_err_s    pw_err_info
);
  import qbsid_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] img0_ctl;
    logic [31:0] img1_ctl;
    logic [31:0] img1_at;
    logic        log_en;
    logic        error_logged_flag;
    logic [3:0]  logged_txn_code;
    logic [1:0]  logged_size_code;
    logic        out_valid;
    qbsid_res_s  res;
  } qbsid_state_s;

  qbsid_state_s st_reg;
  qbsid_state_s st_next;

  logic        wr_fire;
  logic [31:0] img0_at;
  logic [31:0] sel_ctl;
  logic [31:0] sel_at;
  logic [31:0] xl_addr;
  logic        req_fire;
  logic        post_write_allow;
  logic        pci_space_select;
  logic        prefetch_allow;
  logic        flag_clear;
  logic [31:0] errcs_view;
  qbsid_kind_e kind_sel;

  assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
  assign wr_fire         = avs_write & st_reg.ack;
  assign req_fire        = qb_req & ~bridge_chip_select_n;

  qbsid_img0_at u_img0_at (
    .clk_sys   (clk_sys),
    .pci_rst_n (pci_rst_n),
    .wr_en     (wr_fire && avs_address == OFS_IMG0_AT),
    .wr_data   (avs_writedata),
    .wr_be     (avs_byteenable),
    .load_en   (rom_load),
    .load_data (rom_img0_at),
    .at_q      (img0_at)
  );

  // Image choice picks the settings of this access
  assign sel_ctl = qb_req_info.image_choice ? st_reg.img1_ctl
                                            : st_reg.img0_ctl;
  assign sel_at  = qb_req_info.image_choice ? st_reg.img1_at
                                            : img0_at;

  qbsid_xlate u_xlate (
    .qb_addr          (qb_req_info.addr),
    .xlate_base_field (sel_at[31:XBASE_LSB]),
    .window_size_code (sel_at[WSIZE_LSB +: 4]),
    .xlate_enable     (sel_at[AT_EN_BIT]),
    .pci_addr         (xl_addr)
  );

  assign post_write_allow = sel_ctl[CTL_POST_BIT];
  assign pci_space_select = sel_ctl[CTL_SPACE_BIT];
  assign prefetch_allow   = sel_ctl[CTL_PREF_BIT];

  always_comb begin
    unique case ({qb_req_info.write, qb_req_info.burst})
      2'b00: kind_sel = (prefetch_allow && !pci_space_select)
                      ? KIND_PF_RD : KIND_DLY_RD;
      2'b01: kind_sel = pci_space_select
                      ? KIND_BUS_ERR : KIND_DLY_RD;
      2'b10: kind_sel = (post_write_allow && !pci_space_select)
                      ? KIND_POST_WR : KIND_DLY_WR;
      2'b11: kind_sel = pci_space_select
                      ? KIND_BUS_ERR : KIND_POST_WR;
    endcase
  end

  assign flag_clear = wr_fire && avs_address == OFS_ERRCS
                      && avs_byteenable[3] && avs_writedata[ERR_FLAG_BIT];

  always_comb begin
    errcs_view = RDATA_ZERO;
    errcs_view[ERR_EN_BIT] = st_reg.log_en;
    errcs_view[ERR_FLAG_BIT] = st_reg.error_logged_flag;
    if (st_reg.error_logged_flag) begin
      errcs_view[TC_LSB +: 4]  = st_reg.logged_txn_code;
      errcs_view[SIZ_LSB +: 2] = st_reg.logged_size_code;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.ack = (avs_read | avs_write) & ~st_reg.ack;
    if (avs_read && !st_reg.ack) begin
      unique case (avs_address)
        OFS_IMG0_CTL: st_next.rdata = st_reg.img0_ctl;
        OFS_IMG0_AT:  st_next.rdata = img0_at;
        OFS_IMG1_CTL: st_next.rdata = st_reg.img1_ctl;
        OFS_IMG1_AT:  st_next.rdata = st_reg.img1_at;
        OFS_ERRCS:    st_next.rdata = errcs_view;
        default:      st_next.rdata = RDATA_ZERO;
      endcase
    end
    if (wr_fire) begin
      unique case (avs_address)
        OFS_IMG0_CTL: st_next.img0_ctl = qbsid_be_merge(st_reg.img0_ctl,
                        avs_writedata, avs_byteenable) & CTL_MASK;
        OFS_IMG1_CTL: st_next.img1_ctl = qbsid_be_merge(st_reg.img1_ctl,
                        avs_writedata, avs_byteenable) & CTL_MASK;
        OFS_IMG1_AT:  st_next.img1_at = qbsid_be_merge(st_reg.img1_at,
                        avs_writedata, avs_byteenable) & AT_MASK;
        OFS_ERRCS: begin
          if (avs_byteenable[3]) begin
            st_next.log_en = avs_writedata[ERR_EN_BIT];
          end
        end
        default: ;
      endcase
    end
    if (flag_clear) begin
      st_next.error_logged_flag = 1'b0;
    end
    // First error is kept; a new event wins over a same-cycle clear
    if (pw_err && st_reg.log_en
        && (!st_reg.error_logged_flag || flag_clear)) begin
      st_next.error_logged_flag = 1'b1;
      st_next.logged_txn_code   = pw_err_info.txn_code;
      st_next.logged_size_code  = pw_err_info.size_code;
    end
    if (rom_load) begin
      st_next.img0_ctl = rom_img0_ctl & ~(32'h1 << CTL_PREF_BIT)
                         & CTL_MASK;
    end
    st_next.out_valid = req_fire;
    if (req_fire) begin
      st_next.res.pci_addr     = xl_addr;
      st_next.res.pci_io_space = pci_space_select;
      st_next.res.kind         = kind_sel;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.img1_ctl <= CTL_RESET;
      st_reg.img1_at  <= AT_RESET;
      st_reg.res.kind <= KIND_DLY_RD;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = st_reg.rdata;
  assign pci_valid    = st_reg.out_valid;
  assign pci_res      = st_reg.res;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_lower_pass: assert property (req_fire |=>
    pci_res.pci_addr[15:0] == $past(qb_req_info.addr[15:0]))
    else $error("lower address lines altered");
  a_xlate_off: assert property (req_fire && !sel_at[AT_EN_BIT] |=>
    pci_res.pci_addr == $past(qb_req_info.addr))
    else $error("address changed with translation off");
  a_xlate_top: assert property (req_fire && sel_at[AT_EN_BIT] |=>
    pci_res.pci_addr[31] == $past(sel_at[31]))
    else $error("A31 not taken from translation field");
  a_single_read: assert property (req_fire && !qb_req_info.write
    && !qb_req_info.burst |=> pci_res.kind ==
    ($past(prefetch_allow && !pci_space_select) ? KIND_PF_RD : KIND_DLY_RD))
    else $error("single read decode wrong");
  a_burst_io_err: assert property (req_fire && qb_req_info.burst
    && pci_space_select |=> pci_valid && pci_res.kind == KIND_BUS_ERR)
    else $error("burst to I/O space not errored");
  a_single_write: assert property (req_fire && qb_req_info.write
    && !qb_req_info.burst |=> pci_res.kind ==
    ($past(post_write_allow && !pci_space_select)
     ? KIND_POST_WR : KIND_DLY_WR))
    else $error("single write decode wrong");
  a_burst_write: assert property (req_fire && qb_req_info.write
    && qb_req_info.burst && !pci_space_select
    |=> pci_res.kind == KIND_POST_WR)
    else $error("burst memory write not posted");
  a_image_space: assert property (req_fire |=>
    pci_res.pci_io_space == $past(qb_req_info.image_choice
      ? st_reg.img1_ctl[CTL_SPACE_BIT] : st_reg.img0_ctl[CTL_SPACE_BIT]))
    else $error("space not from chosen image");
  a_errlog_set: assert property (pw_err && st_reg.log_en
    && !st_reg.error_logged_flag |=> st_reg.error_logged_flag
    && st_reg.logged_txn_code == $past(pw_err_info.txn_code))
    else $error("posted write error not logged");
  a_errlog_zero: assert property (avs_read && !st_reg.ack
    && avs_address == OFS_ERRCS && !st_reg.error_logged_flag
    && !pw_err |=> avs_readdata[7:0] == 8'h00)
    else $error("log fields visible with flag clear");
  a_bus_answer: assert property (avs_read && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("read not answered in one wait cycle");
  a_write_answer: assert property (avs_write && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("write not answered in one wait cycle");

  a_burst_rd_mem: assert property (req_fire && !qb_req_info.write
    && qb_req_info.burst && !pci_space_select
    |=> pci_res.kind == KIND_DLY_RD)
    else $error("burst memory read not delayed");
  a_io_write_dly: assert property (req_fire && qb_req_info.write
    && !qb_req_info.burst && pci_space_select
    |=> pci_res.kind == KIND_DLY_WR)
    else $error("single I/O write not delayed");
  a_space_memory: assert property (req_fire && !pci_space_select
    |=> !pci_res.pci_io_space)
    else $error("memory space not issued");
  a_space_io: assert property (req_fire && pci_space_select
    |=> pci_res.pci_io_space)
    else $error("I/O space not issued");
  a_full_window: assert property (req_fire && sel_at[AT_EN_BIT]
    && sel_at[WSIZE_LSB +: 4] == 4'h0
    |=> pci_res.pci_addr[31:16] == $past(sel_at[31:16]))
    else $error("64 KB window not fully translated");
  a_top_window: assert property (req_fire && sel_at[AT_EN_BIT]
    && sel_at[WSIZE_LSB +: 4] == 4'hF
    |=> pci_res.pci_addr[30:16] == $past(qb_req_info.addr[30:16]))
    else $error("largest window translated too many lines");
  a_img0_plain: assert property (req_fire
    && !qb_req_info.image_choice && !img0_at[AT_EN_BIT]
    |=> pci_res.pci_addr == $past(qb_req_info.addr))
    else $error("image 0 translated while disabled");
  a_img1_top: assert property (req_fire && qb_req_info.image_choice
    && st_reg.img1_at[AT_EN_BIT]
    |=> pci_res.pci_addr[31] == $past(st_reg.img1_at[31]))
    else $error("image 1 translation not applied");
  a_valid_pulse: assert property (req_fire |=> pci_valid)
    else $error("taken access not answered");
  a_no_select: assert property (!req_fire |=> !pci_valid)
    else $error("answer without a taken access");
  a_errlog_keep: assert property (pw_err && st_reg.error_logged_flag
    && !flag_clear |=> st_reg.error_logged_flag
    && st_reg.logged_txn_code == $past(st_reg.logged_txn_code))
    else $error("first logged error overwritten");
  a_errlog_off: assert property (pw_err && !st_reg.log_en
    && !st_reg.error_logged_flag |=> !st_reg.error_logged_flag)
    else $error("error logged while logging disabled");
  a_flag_clear: assert property (flag_clear && !pw_err
    |=> !st_reg.error_logged_flag)
    else $error("error flag not cleared");
  a_rom_noprefetch: assert property (rom_load
    |=> !st_reg.img0_ctl[CTL_PREF_BIT])
    else $error("prefetch allow loaded from ROM");
  a_rom_xlate: assert property (rom_load && pci_rst_n
    |=> img0_at == $past(rom_img0_at & AT_MASK))
    else $error("image 0 translation not loaded");

  c_prefetch: cover property (req_fire && kind_sel == KIND_PF_RD);
  c_bus_err:  cover property (req_fire && kind_sel == KIND_BUS_ERR);
  c_img1_xl:  cover property (req_fire && qb_req_info.image_choice
                              && sel_at[AT_EN_BIT]);
  c_err_log:  cover property (pw_err && st_reg.log_en);
  c_burst_wr: cover property (req_fire && qb_req_info.write
                              && qb_req_info.burst);

endmodule

//--- src/qbsid_pkg.sv
/*
 Constants and carrier types of the QBus slave image decoder.
 Assumes byte addressing on a 32-bit Avalon-MM register port.
*/
package qbsid_pkg;

  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_IMG0_CTL  = 12'hF00;
  localparam logic [11:0] OFS_IMG0_AT   = 12'hF04;
  localparam logic [11:0] OFS_IMG1_CTL  = 12'hF10;
  localparam logic [11:0] OFS_IMG1_AT   = 12'hF14;
  localparam logic [11:0] OFS_ERRCS     = 12'hF80;

  // Control register fields
  localparam int CTL_POST_BIT  = 31;
  localparam int CTL_SPACE_BIT = 24;
  localparam int CTL_PREF_BIT  = 23;
  localparam logic [31:0] CTL_MASK = 32'h8180_0000;

  // Translation register fields
  localparam int XBASE_LSB   = 16;
  localparam int WSIZE_LSB   = 4;
  localparam int AT_EN_BIT   = 0;
  localparam logic [31:0] AT_MASK = 32'hFFFF_00F1;

  // Error log fields
  localparam int ERR_EN_BIT  = 31;
  localparam int ERR_FLAG_BIT = 24;
  localparam int TC_LSB      = 4;
  localparam int SIZ_LSB     = 0;

  localparam logic [31:0] CTL_RESET   = 32'h0000_0000;
  localparam logic [31:0] AT_RESET    = 32'h0000_0000;
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

  typedef enum logic [4:0] {
    KIND_DLY_RD  = 5'b00001,
    KIND_PF_RD   = 5'b00010,
    KIND_DLY_WR  = 5'b00100,
    KIND_POST_WR = 5'b01000,
    KIND_BUS_ERR = 5'b10000
  } qbsid_kind_e;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        burst;
    logic        image_choice;
  } qbsid_req_s;

  typedef struct packed {
    logic [31:0] pci_addr;
    logic        pci_io_space;
    qbsid_kind_e kind;
  } qbsid_res_s;

  typedef struct packed {
    logic [3:0] txn_code;
    logic [1:0] size_code;
  } qbsid_err_s;

  function automatic logic [31:0] qbsid_be_merge(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

//--- src/qbsid_xlate.sv
/*
 Address substitution for one slave image.
 Assumes the image fields are stable during the access.
*/
`timescale 1ns/1ps
module qbsid_xlate (
  input  wire logic [31:0] qb_addr,
  input  wire logic [15:0] xlate_base_field,
  input  wire logic [3:0]  window_size_code,
  input  wire logic        xlate_enable,
  output logic [31:0]      pci_addr
);
  import qbsid_pkg::*;

  logic [15:0] line_mask;

  always_comb begin
    // Lines A31 down to A(16+code) are replaced
    line_mask = 16'hFFFF << window_size_code;
    if (xlate_enable) begin
      pci_addr[31:16] = (xlate_base_field & line_mask)
                      | (qb_addr[31:16] & ~line_mask);
    end else begin
      pci_addr[31:16] = qb_addr[31:16];
    end
    pci_addr[15:0] = qb_addr[15:0];
  end

endmodule

//--- src/qbsid_img0_at.sv
/*
 Image 0 translation register, held in the PCI reset domain.
 Assumes a one-cycle load strobe from the serial ROM loader.
*/
`timescale 1ns/1ps
module qbsid_img0_at (
  input  wire logic        clk_sys,
  input  wire logic        pci_rst_n,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  wr_be,
  input  wire logic        load_en,
  input  wire logic [31:0] load_data,
  output logic [31:0]      at_q
);
  import qbsid_pkg::*;

  typedef struct packed {
    logic [31:0] at_reg;
  } qbsid_at_state_s;

  qbsid_at_state_s st_reg;
  qbsid_at_state_s st_next;

  always_comb begin
    st_next = st_reg;
    if (load_en) begin
      st_next.at_reg = load_data & AT_MASK;
    end else if (wr_en) begin
      st_next.at_reg = qbsid_be_merge(st_reg.at_reg, wr_data, wr_be)
                     & AT_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge pci_rst_n) begin
    if (!pci_rst_n) begin
      st_reg <= '{at_reg: AT_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign at_q = st_reg.at_reg;

endmodule

//--- tb/qbsid_qbus_model.sv
/*
 QBus master model: presents slave accesses and posted-write error events.
 Assumes the decoder answers with a one-cycle pci_valid pulse.
*/
`timescale 1ns/1ps
module qbsid_qbus_model (
  input  wire logic                  clk_sys,
  input  wire logic                  pci_valid,
  input  wire qbsid_pkg::qbsid_res_s pci_res,
  output logic                       qb_req,
  output logic                       bridge_chip_select_n,
  output qbsid_pkg::qbsid_req_s      qb_req_info,
  output logic                       pw_err,
  output qbsid_pkg::qbsid_err_s      pw_err_info
);
  import qbsid_pkg::*;

  initial begin
    qb_req = 1'b0;
    bridge_chip_select_n = 1'b1;
    qb_req_info = '0;
    pw_err = 1'b0;
    pw_err_info = '0;
  end

  // One access; released qb_req_info shows the inverse of the last value, qb_req goes low and cs_n goes high
  task automatic access(input qbsid_req_s rq, input logic cs_n,
                        output qbsid_res_s rs, output logic ok);
    int n;
    ok = 1'b0;
    rs = '0;
    n = 0;
    @(posedge clk_sys);
    qb_req <= 1'b1;
    bridge_chip_select_n <= cs_n;
    qb_req_info <= rq;
    @(posedge clk_sys);
    qb_req <= 1'b0;
    bridge_chip_select_n <= 1'b1;
    qb_req_info <= ~rq;
    while (!ok && n < 4) begin
      @(negedge clk_sys);
      n++;
      if (pci_valid === 1'b1) begin
        ok = 1'b1;
        rs = pci_res;
      end
    end
  endtask

  // Posted write drained with a bus error
  task automatic pw_event(input qbsid_err_s e);
    @(posedge clk_sys);
    pw_err <= 1'b1;
    pw_err_info <= e;
    @(posedge clk_sys);
    pw_err <= 1'b0;
    pw_err_info <= ~e;
  endtask
endmodule

//--- tb/qbsid_top_tb_top.sv
/*
 Testbench of the QBus slave image decoder.
 Assumes the register map and one-wait-cycle Avalon-MM slave of the package.
*/
`timescale 1ns/1ps
module qbsid_top_tb_top;
  import qbsid_pkg::*;
  logic              clk_sys, rst_n, pci_rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest;
  logic [31:0]       avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic              rom_load, qb_req, cs_n, pci_valid, pw_err;
  logic [31:0]       rom_img0_ctl, rom_img0_at, q;
  qbsid_req_s        info;
  qbsid_res_s        pci_res;
  qbsid_err_s        pw_err_info;
  int                error_cnt, check_count;

  qbsid_top u_qbsid_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .pci_rst_n(pci_rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rom_load(rom_load), .rom_img0_ctl(rom_img0_ctl),
    .rom_img0_at(rom_img0_at), .qb_req(qb_req),
    .bridge_chip_select_n(cs_n), .qb_req_info(info),
    .pci_valid(pci_valid), .pci_res(pci_res), .pw_err(pw_err),
    .pw_err_info(pw_err_info));

  qbsid_qbus_model u_qbsid_qbus_model (.clk_sys(clk_sys),
    .pci_valid(pci_valid), .pci_res(pci_res), .qb_req(qb_req),
    .bridge_chip_select_n(cs_n), .qb_req_info(info), .pw_err(pw_err),
    .pw_err_info(pw_err_info));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t word got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_res(input qbsid_res_s g, input qbsid_res_s e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t result got %h exp %h", $time, g, e);
    end
  endtask

  // Avalon-MM access held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int   n;
    logic hung;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 8);
    hung = (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (hung) begin
      error_cnt++;
      $display("[ERR] %0t bus request not answered", $time);
      complete_run();
    end
  endtask

  task automatic rreg(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk32(q, e);
  endtask

  function automatic qbsid_kind_e exp_kind(logic w, b, pw, spc, pf);
    if (b && spc) return KIND_BUS_ERR;
    if (w) return ((b || pw) && !spc) ? KIND_POST_WR : KIND_DLY_WR;
    return (!b && pf && !spc) ? KIND_PF_RD : KIND_DLY_RD;
  endfunction

  function automatic logic [31:0] exp_addr(logic [31:0] a, logic [31:0] t);
    logic [31:0] m;
    m = 32'hFFFF_FFFF << (16 + t[7:4]);
    if (!t[0]) return a;
    return (t & m) | (a & ~m);
  endfunction

  task automatic reset_values();
    logic [11:0] regs [5] = '{12'hF00, 12'hF04, 12'hF10, 12'hF14, 12'hF80};
    foreach (regs[i]) rreg(regs[i], 32'h0000_0000);
    rreg(12'hF20, 32'h0000_0000);
  endtask

  task automatic rom_and_pci_reset();
    @(posedge clk_sys);
    rom_load <= 1'b1;
    @(posedge clk_sys);
    rom_load <= 1'b0;
    rreg(OFS_IMG0_CTL, 32'h8100_0000);
    rreg(OFS_IMG0_AT, 32'h1357_0081);
    @(posedge clk_sys);
    pci_rst_n <= 1'b0;
    @(posedge clk_sys);
    pci_rst_n <= 1'b1;
    rreg(OFS_IMG0_AT, 32'h0000_0000);
    bus(1'b1, OFS_IMG1_AT, 32'hFFFF_FFFF);
    rreg(OFS_IMG1_AT, AT_MASK);
    bus(1'b1, OFS_IMG1_CTL, 32'hFFFF_FFFF);
    rreg(OFS_IMG1_CTL, CTL_MASK);
  endtask

  task automatic decode(input logic [31:0] at0, input logic [31:0] at1);
    qbsid_req_s rq;
    qbsid_res_s rs, ex;
    logic ok;
    bus(1'b1, OFS_IMG0_AT, at0);
    bus(1'b1, OFS_IMG1_AT, at1);
    for (int i = 0; i < 2; i++) begin
      for (int c = 0; c < 8; c++) begin
        bus(1'b1, i ? OFS_IMG1_CTL : OFS_IMG0_CTL,
            {c[2], 6'h00, c[1], c[0], 23'h000000});
        for (int k = 0; k < 4; k++) begin
          rq = '{32'h1234_5678, k[1], k[0], i[0]};
          u_qbsid_qbus_model.access(rq, 1'b0, rs, ok);
          ex = '{exp_addr(32'h1234_5678, i ? at1 : at0), c[1],
                 exp_kind(k[1], k[0], c[2], c[1], c[0])};
          chk_res(rs, ex);
        end
      end
    end
    u_qbsid_qbus_model.access(rq, 1'b1, rs, ok);
    chk32({31'h0, ok}, 32'h0000_0000);
  endtask

  task automatic error_log();
    rreg(OFS_ERRCS, 32'h0000_0000);
    bus(1'b1, OFS_ERRCS, 32'h8000_0000);
    rreg(OFS_ERRCS, 32'h8000_0000);
    u_qbsid_qbus_model.pw_event('{4'hB, 2'h2});
    rreg(OFS_ERRCS, 32'h8100_00B2);
    u_qbsid_qbus_model.pw_event('{4'h3, 2'h1});
    rreg(OFS_ERRCS, 32'h8100_00B2);
    bus(1'b1, OFS_ERRCS, 32'h8100_0000);
    rreg(OFS_ERRCS, 32'h8000_0000);
    bus(1'b1, OFS_ERRCS, 32'h0000_0000);
    u_qbsid_qbus_model.pw_event('{4'h5, 2'h3});
    rreg(OFS_ERRCS, 32'h0000_0000);
  endtask

  initial begin
    error_cnt = 0;
    check_count = 0;
    rst_n = 1'b0;
    pci_rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    rom_load = 1'b0;
    rom_img0_ctl = 32'hFFFF_FFFF;
    rom_img0_at = 32'h1357_0081;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    pci_rst_n <= 1'b1;
    reset_values();
    rom_and_pci_reset();
    decode(32'hA5A5_0031, 32'h5A5A_00F1);
    decode(32'hA5A5_0000, 32'h5A5A_0001);
    error_log();
    complete_run();
  end
endmodule
